// File: hw/rtcac_pkg.sv
// package: register map, field positions, reset values for the rtc alarm compare block
package rtcac_pkg;
    // =========================================================
    // register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_MATCH = 4'h4;
    localparam logic [3:0] REG_TIMER = 4'h8;
    localparam logic [3:0] REG_IRQ_STATUS = 4'hc;
    // =========================================================
    // control fields
    localparam int CTRL_ALARM_EN = 0;
    localparam int CTRL_AUTO_RST = 1;
    localparam int CTRL_RESET_EN = 2;
    localparam int CTRL_WAKE_EN = 3;
    localparam int CTRL_IRQ_EN = 4;
    localparam int CTRL_TIMER_RUN = 5;
    localparam int CTRL_WIDTH = 6;
    // =========================================================
    // reset values, timer step and irq status bit position
    localparam logic [5:0] CTRL_RESET = 6'h20;
    localparam logic [31:0] MATCH_RESET = 32'hffffffff;
    localparam logic [31:0] TIMER_RESET = 32'h00000000;
    localparam logic [31:0] TIMER_ONE = 32'h00000001;
    localparam int IRQ_ALARM = 0;
endpackage

// File: hw/rtcac_match.sv
// module: 32-bit free-running timer with exact alarm match and auto reset
`timescale 1ns/100ps
module rtcac_match (
    input wire logic clk,
    input wire logic resetn,
    input wire logic timerRun,
    input wire logic alarmEnable,
    input wire logic autoReset,
    input wire logic timerLoad,
    input wire logic [31:0] timerLoadValue,
    input wire logic [31:0] alarmMatchValue,
    output logic [31:0] timerValue,
    output logic matchEvent
);
    // =========================================================
    // timer
    logic autoClear_r;
    logic matchHit;

    assign matchHit = alarmEnable && (timerValue == alarmMatchValue);

    // wrap freely, clear one cycle later
    always_ff @(posedge clk) begin
        if (!resetn) begin
            timerValue <= rtcac_pkg::TIMER_RESET;
        end else if (timerLoad) begin
            timerValue <= timerLoadValue;
        end else if (autoClear_r) begin
            timerValue <= rtcac_pkg::TIMER_RESET;
        end else if (timerRun) begin
            timerValue <= timerValue + rtcac_pkg::TIMER_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            autoClear_r <= 1'b0;
        end else begin
            autoClear_r <= matchHit && autoReset;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            matchEvent <= 1'b0;
        end else begin
            matchEvent <= matchHit && !timerLoad;
        end
    end
endmodule

// File: hw/rtcac_top.sv
// module: alarm compare top with register port, actions and interrupt
//
// Contract
// - alarm only on exact 32-bit equality
// - auto reset clears timer one cycle later
// - alarm may reset, wake or interrupt
// - writing enable low clears alarm flag
// - re-enable without change waits full wrap
// - alarm flag lasts one cycle while the timer runs; stays high while a stopped timer equals match
// - timer wraps freely without auto reset
// - match value kept across alarms
`timescale 1ns/100ps
module rtcac_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic alarmEventFlag,
    output logic alarmResetReq,
    output logic alarmWakeReq,
    output logic irq
);
    // =========================================================
    // registers
    logic [5:0] ctrl_r;
    logic [31:0] alarmMatchValueRegs_r;
    logic irqStatus_r;
    logic [31:0] timerValue;
    logic matchEvent;
    logic wrCtrl;
    logic wrTimer;
    logic disableWrite;
    logic eventQual;

    assign wrCtrl = regWrite && (regAddr == rtcac_pkg::REG_CTRL);
    assign wrTimer = regWrite && (regAddr == rtcac_pkg::REG_TIMER);
    assign disableWrite = wrCtrl && !regWdata[rtcac_pkg::CTRL_ALARM_EN];
    // a disabling write kills a pending event
    assign eventQual = matchEvent && !disableWrite && ctrl_r[rtcac_pkg::CTRL_ALARM_EN];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_r <= rtcac_pkg::CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl_r <= regWdata[rtcac_pkg::CTRL_WIDTH-1:0];
        end
    end

    // match only changes on software write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            alarmMatchValueRegs_r <= rtcac_pkg::MATCH_RESET;
        end else if (regWrite && (regAddr == rtcac_pkg::REG_MATCH)) begin
            alarmMatchValueRegs_r <= regWdata;
        end
    end

    // =========================================================
    // timer and comparator
    // no rearm shortcut, next hit needs full wrap
    // timer wraps the same way software adds
    rtcac_match u_match (
        .clk(clk),
        .resetn(resetn),
        .timerRun(ctrl_r[rtcac_pkg::CTRL_TIMER_RUN]),
        .alarmEnable(ctrl_r[rtcac_pkg::CTRL_ALARM_EN]),
        .autoReset(ctrl_r[rtcac_pkg::CTRL_AUTO_RST]),
        .timerLoad(wrTimer),
        .timerLoadValue(regWdata),
        .alarmMatchValue(alarmMatchValueRegs_r),
        .timerValue(timerValue),
        .matchEvent(matchEvent)
    );

    // =========================================================
    // event flag and actions
    // flag is a single-cycle pulse while the timer runs, held while a stopped timer equals match
    always_ff @(posedge clk) begin
        if (!resetn) begin
            alarmEventFlag <= 1'b0;
        end else begin
            alarmEventFlag <= eventQual;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            alarmResetReq <= 1'b0;
            alarmWakeReq <= 1'b0;
        end else begin
            alarmResetReq <= eventQual && ctrl_r[rtcac_pkg::CTRL_RESET_EN];
            alarmWakeReq <= eventQual && ctrl_r[rtcac_pkg::CTRL_WAKE_EN];
        end
    end

    // =========================================================
    // interrupt: sticky status, set wins over write-one clear
    // status records every event; the irq enable bit only masks the line
    // interrupt action
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irqStatus_r <= 1'b0;
        end else if (eventQual) begin
            irqStatus_r <= 1'b1;
        end else if (regWrite && (regAddr == rtcac_pkg::REG_IRQ_STATUS) && regWdata[rtcac_pkg::IRQ_ALARM]) begin
            irqStatus_r <= 1'b0;
        end
    end

    // irq enable bit of ctrl doubles as the mask of the status bit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irqStatus_r && ctrl_r[rtcac_pkg::CTRL_IRQ_EN];
        end
    end

    // =========================================================
    // read port, one cycle latency, unmapped reads zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            regRdata <= 32'h00000000;
        end else if (regRead) begin
            unique case (regAddr)
                rtcac_pkg::REG_CTRL: regRdata <= {26'h0, ctrl_r};
                rtcac_pkg::REG_MATCH: regRdata <= alarmMatchValueRegs_r;
                rtcac_pkg::REG_TIMER: regRdata <= timerValue;
                rtcac_pkg::REG_IRQ_STATUS: regRdata <= {31'h0, irqStatus_r};
                default: regRdata <= 32'h00000000;
            endcase
        end else begin
            regRdata <= 32'h00000000;
        end
    end
endmodule

// File: tb/rtcac_monitor.sv
// checker: alarm compare port assertions
`timescale 1ns/100ps
module rtcac_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic alarmEventFlag,
    input wire logic alarmResetReq,
    input wire logic alarmWakeReq,
    input wire logic irq
);
    // ====================
    // shadows rebuilt from writes, so checks need no internals
    logic [5:0] ctrl_r;
    logic [31:0] match_r;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_r <= rtcac_pkg::CTRL_RESET;
            match_r <= rtcac_pkg::MATCH_RESET;
        end else if (regWrite && regAddr == rtcac_pkg::REG_CTRL) begin
            ctrl_r <= regWdata[5:0];
        end else if (regWrite && regAddr == rtcac_pkg::REG_MATCH) begin
            match_r <= regWdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence quietTwo;
        !alarmEventFlag [*2];
    endsequence
    // ====================
    // assertions
    flag_one_cycle_a: assert property (alarmEventFlag |=> !alarmEventFlag) else $error("flag too long");
    flag_needs_enable_a: assert property (alarmEventFlag |-> ctrl_r[0]) else $error("flag while off");
    disable_clears_flag_a: assert property (regWrite && regAddr == rtcac_pkg::REG_CTRL && !regWdata[0]
        |=> quietTwo) else $error("flag after disable");
    reset_req_gated_a: assert property (alarmResetReq |-> alarmEventFlag && $past(ctrl_r[2])) else $error("reset req");
    wake_req_gated_a: assert property (alarmWakeReq |-> alarmEventFlag && $past(ctrl_r[3])) else $error("wake req");
    irq_masked_a: assert property (!$past(ctrl_r[4]) |-> !irq) else $error("irq while masked");
    irq_cause_a: assert property ($rose(irq) |-> $past(alarmEventFlag) || $past(alarmEventFlag, 2)
        || $past(regWrite, 2)) else $error("irq without cause");
    match_kept_a: assert property (regRead && regAddr == rtcac_pkg::REG_MATCH
        |=> regRdata == $past(match_r)) else $error("match value changed");
endmodule

// File: tb/rtc_alarm_compare_tb_top.sv
// testbench: alarm compare top through its register port
`timescale 1ns/100ps
module rtc_alarm_compare_tb_top;
    logic clk = 0, resetn = 0, regWrite = 0, regRead = 0, rdPend = 0;
    logic [3:0] regAddr = 0;
    logic [31:0] regWdata = 0, regRdata, m;
    logic alarmEventFlag, alarmResetReq, alarmWakeReq, irq;
    logic [31:0] expQ[$];
    int mismatches = 0, compares = 0, n;
    always #25 clk = ~clk;
    rtcac_top i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .alarmEventFlag(alarmEventFlag), .alarmResetReq(alarmResetReq),
        .alarmWakeReq(alarmWakeReq), .irq(irq));
    // ====================
    // helpers
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(0, 1, a, 0);
    endtask
    // bounded wait, strobes dropped first
    task waitFlag;
        n = 0;
        regWrite <= 0;
        regRead <= 0;
        do begin
            @(posedge clk);
            n++;
        end while (alarmEventFlag !== 1'b1 && n < 300);
    endtask
    task tally_and_finish;
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rdPend)
            chk("rdata", regRdata, expQ.pop_front());
        rdPend <= regRead;
    end
    initial begin
        #1ms;
        mismatches++;
        tally_and_finish;
    end
    // ====================
    // main sequence
    initial begin
        void'($urandom(32'h2dbc9dfe));
        repeat (5) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        rd(rtcac_pkg::REG_CTRL, 32'h20);
        rd(rtcac_pkg::REG_MATCH, 32'hffffffff);
        rd(4'h2, 32'h0);
        // timer loaded near the top wraps on without a stop
        bus(1, 0, rtcac_pkg::REG_TIMER, 32'hfffffffe);
        rd(rtcac_pkg::REG_TIMER, 32'hfffffffe);
        rd(rtcac_pkg::REG_TIMER, 32'hffffffff);
        rd(rtcac_pkg::REG_TIMER, 32'h0);
        // random match, exact equality, all actions off
        m = $urandom;
        bus(1, 0, rtcac_pkg::REG_CTRL, 32'h20);
        bus(1, 0, rtcac_pkg::REG_MATCH, m);
        bus(1, 0, rtcac_pkg::REG_TIMER, m - 32'h5);
        bus(1, 0, rtcac_pkg::REG_CTRL, 32'h21);
        waitFlag;
        chk("match delay", n, 7);
        chk("reset off", alarmResetReq, 0);
        rd(rtcac_pkg::REG_MATCH, m);
        // re-arm unchanged: next hit only after a full wrap
        bus(1, 0, rtcac_pkg::REG_CTRL, 32'h20);
        bus(1, 0, rtcac_pkg::REG_CTRL, 32'h21);
        waitFlag;
        chk("rearm", n, 300);
        // periodic auto reset with every action on
        bus(1, 0, rtcac_pkg::REG_CTRL, 32'h20);
        bus(1, 0, rtcac_pkg::REG_MATCH, 32'h14);
        bus(1, 0, rtcac_pkg::REG_TIMER, 32'h0);
        bus(1, 0, rtcac_pkg::REG_CTRL, 32'h3f);
        waitFlag;
        chk("reset req", alarmResetReq, 1);
        chk("wake req", alarmWakeReq, 1);
        waitFlag;
        chk("period", n, 22);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1);
        rd(rtcac_pkg::REG_IRQ_STATUS, 32'h1);
        bus(1, 0, rtcac_pkg::REG_IRQ_STATUS, 32'h1);
        bus(1, 0, rtcac_pkg::REG_CTRL, 32'h2f);
        rd(rtcac_pkg::REG_IRQ_STATUS, 32'h0);
        waitFlag;
        repeat (2) @(posedge clk);
        chk("irq masked", irq, 0);
        rd(rtcac_pkg::REG_IRQ_STATUS, 32'h1);
        bus(0, 0, 0, 0);
        tally_and_finish;
    end
endmodule
bind rtcac_top rtcac_monitor i_mon (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .alarmEventFlag(alarmEventFlag),
    .alarmResetReq(alarmResetReq), .alarmWakeReq(alarmWakeReq), .irq(irq));
